// ### rtl/event_latch.sv
`timescale 1ns/1ps
module event_latch #(
   parameter int N = 16
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [N-1:0] event_pulse,
   input  wire logic         clear,
   output logic      [N-1:0] latched
);
   logic [N-1:0] latched_reg;
   logic [N-1:0] latched_next;

   // Elaboration guard; a latch with no bits has no meaning
   generate
      if (N < 1) begin : g_bad_width
         $error("event_latch: N must be positive");
      end
   endgenerate

   // Per bit, a new event beats a clear in the same cycle
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_bit
         always_comb begin
            latched_next[i] = (clear ? 1'b0 : latched_reg[i]) | event_pulse[i];
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         latched_reg <= '0;
      end else begin
         latched_reg <= latched_next;
      end
   end

   assign latched = latched_reg;
endmodule

// ### rtl/link_status_summary_and_int_enable.sv
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Functional notes
// [RULE1] Two-bit speed field: 10, 100, 1000 codes
// [RULE2] Full duplex bit reads one when full
// [RULE3] Page received latches high, clears on read
// [RULE4] Resolved bit: negotiation done or disabled
// [RULE5] Link up bit reports current link
// [RULE6] Crossover bits for C/D and A/B pairs
// [RULE7] Downshift masking bit during negotiation
// [RULE8] Sleep bit: one sleeping, zero active
// [RULE9] Gigabit channel polarity D,C,B,A reversed bits
// [RULE10] Ten-megabit polarity bit, one means normal
// [RULE11] Jabber bit reads one while present
// [RULE12] Interrupt only for enabled events
// [RULE13] Read-write enables, reset to zero
// [RULE14] Enables 15..8 map upper event sources
// [RULE15] Enables 7..0 map lower event sources
// [RULE16] Events latch regardless of enable
// [RULE17] Interrupt pin polarity bit, resets to one
// [RULE18] Interrupt while enabled latched event pending
module link_status_summary_and_int_enable
   import link_status_summary_pkg::*;
(
   input  wire logic                             SYS_CLK,
   input  wire logic                             RST,
   input  wire logic [link_status_summary_pkg::ADDR_W-1:0] AVS_ADDRESS,
   input  wire logic                             AVS_READ,
   input  wire logic                             AVS_WRITE,
   input  wire logic [31:0]                      AVS_WRITEDATA,
   input  wire logic [3:0]                       AVS_BYTEENABLE,
   output logic      [31:0]                      AVS_READDATA,
   output logic                                  AVS_WAITREQUEST,
   input  wire logic [1:0]                       LINK_SPEED,
   input  wire logic                             FULL_DUPLEX_FLAG,
   input  wire logic                             PAGE_RECEIVED_PULSE,
   input  wire logic                             NEGOTIATION_RESOLVED_FLAG,
   input  wire logic                             LINK_UP,
   input  wire logic                             PAIRS_CD_CROSSED,
   input  wire logic                             PAIRS_AB_CROSSED,
   input  wire logic                             DOWNSHIFT_MASKING_ACTIVE,
   input  wire logic                             SLEEPING,
   input  wire logic [3:0]                       CHANNEL_POLARITY_REVERSED,
   input  wire logic                             TEN_POLARITY_NORMAL,
   input  wire logic                             OVERLONG_TX_DETECTED,
   input  wire logic [link_status_summary_pkg::EVENT_N-1:0] EVENT_PULSES,
   output logic                                  IRQ_PIN
);
   import link_status_summary_pkg::*;

   logic [15:0] irq_enable_reg;
   logic [15:0] irq_enable_next;
   logic        irq_polarity_reg;
   logic        irq_polarity_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        ack_reg;
   logic        ack_next;
   logic        waitreq_reg;
   logic        waitreq_next;
   logic        irq_reg;
   logic        irq_next;
   logic [15:0] status_word;
   logic [15:0] event_status;
   logic        page_latched;
   logic        page_clear;
   logic        event_clear;
   logic        sel_read;
   logic        sel_write;
   logic [7:0]  word_idx;
   logic        addr_ok;

   // Word index; low two address bits are byte offset and are ignored
   assign word_idx = AVS_ADDRESS[ADDR_W-1:2];
   // A request is served in the cycle after it is seen, then the ack drops
   assign sel_read  = AVS_READ && !ack_reg;
   assign sel_write = AVS_WRITE && !ack_reg;
   assign addr_ok   = (word_idx >= IDX_LINK_STATUS_SUMMARY) &&
                      (word_idx <= IDX_EVENT_IRQ_CONTROL);

   // [RULE3] page received latch
   event_latch #(.N(1)) u_page_latch (
      .clk         (SYS_CLK),
      .rst         (RST),
      .event_pulse (PAGE_RECEIVED_PULSE),
      .clear       (page_clear),
      .latched     (page_latched)
   );
   // [RULE3] clear on a summary read
   assign page_clear = sel_read && (word_idx == IDX_LINK_STATUS_SUMMARY);

   // [RULE16] events latch whatever the enables say
   event_latch #(.N(EVENT_N)) u_event_latch (
      .clk         (SYS_CLK),
      .rst         (RST),
      .event_pulse (EVENT_PULSES),
      .clear       (event_clear),
      .latched     (event_status)
   );
   // Reading the event status clears it, a new event in that cycle survives
   assign event_clear = sel_read && (word_idx == IDX_EVENT_STATUS);

   // Assemble the read-only summary from live status and the latched page bit
   always_comb begin
      status_word = RESET_STATUS_SUMMARY;
      // [RULE1] speed field
      status_word[POS_SPEED +: 2] = LINK_SPEED;
      // [RULE2] duplex bit
      status_word[POS_FULL_DUPLEX] = FULL_DUPLEX_FLAG;
      // [RULE3] latched page bit
      status_word[POS_PAGE_RECEIVED] = page_latched;
      // [RULE4] resolution bit
      status_word[POS_NEG_RESOLVED] = NEGOTIATION_RESOLVED_FLAG;
      // [RULE5] link state
      status_word[POS_LINK_UP] = LINK_UP;
      // [RULE6] crossover bits
      status_word[POS_CD_CROSSED] = PAIRS_CD_CROSSED;
      status_word[POS_AB_CROSSED] = PAIRS_AB_CROSSED;
      // [RULE7] downshift masking
      status_word[POS_DOWNSHIFT] = DOWNSHIFT_MASKING_ACTIVE;
      // [RULE8] sleep state
      status_word[POS_SLEEP] = SLEEPING;
      // [RULE9] channel polarity
      status_word[POS_CHAN_POLARITY +: 4] = CHANNEL_POLARITY_REVERSED;
      // [RULE10] inverted-sense polarity passes as is
      status_word[POS_TEN_POLARITY] = TEN_POLARITY_NORMAL;
      // [RULE11] jabber bit
      status_word[POS_OVERLONG_TX] = OVERLONG_TX_DETECTED;
   end

   // Register writes honour byte lanes; read-only words ignore writes
   always_comb begin
      irq_enable_next   = irq_enable_reg;
      irq_polarity_next = irq_polarity_reg;
      if (sel_write) begin
         // [RULE13] enables are plain read-write
         if (word_idx == IDX_EVENT_INTERRUPT_ENABLE) begin
            if (AVS_BYTEENABLE[0]) begin
               irq_enable_next[7:0] = AVS_WRITEDATA[7:0];
            end
            if (AVS_BYTEENABLE[1]) begin
               irq_enable_next[15:8] = AVS_WRITEDATA[15:8];
            end
         end
         // [RULE17] polarity control
         if (word_idx == IDX_EVENT_IRQ_CONTROL && AVS_BYTEENABLE[1]) begin
            irq_polarity_next = AVS_WRITEDATA[POS_IRQ_POLARITY];
         end
      end
   end

   // Read mux; unmapped words read zero and still complete
   always_comb begin
      rdata_next = rdata_reg;
      ack_next   = (AVS_READ || AVS_WRITE) && !ack_reg;
      // Own flop so the bus sees no gate between register and pin
      waitreq_next = !ack_next;
      if (sel_read) begin
         rdata_next = 32'h0000_0000;
         if (addr_ok) begin
            unique case (word_idx)
               IDX_LINK_STATUS_SUMMARY:    rdata_next[15:0] = status_word;
               IDX_EVENT_INTERRUPT_ENABLE: rdata_next[15:0] = irq_enable_reg;
               IDX_EVENT_STATUS:           rdata_next[15:0] = event_status;
               IDX_EVENT_IRQ_CONTROL: begin
                  rdata_next[POS_IRQ_POLARITY] = irq_polarity_reg;
               end
               default:                    rdata_next = 32'h0000_0000;
            endcase
         end
      end
   end

   // Interrupt request and pin level
   always_comb begin
      // [RULE12] [RULE14] [RULE15] bit i of enable gates event i
      // [RULE18] request holds while any enabled event stays latched
      // [RULE17] pin inverted when polarity bit is one
      irq_next = (|(event_status & irq_enable_reg)) ^ irq_polarity_reg;
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         irq_enable_reg   <= RESET_IRQ_ENABLE;
         irq_polarity_reg <= RESET_IRQ_POLARITY;
         rdata_reg        <= 32'h0000_0000;
         ack_reg          <= 1'b0;
         waitreq_reg      <= 1'b1;
         irq_reg          <= RESET_IRQ_POLARITY;
      end else begin
         irq_enable_reg   <= irq_enable_next;
         irq_polarity_reg <= irq_polarity_next;
         rdata_reg        <= rdata_next;
         ack_reg          <= ack_next;
         waitreq_reg      <= waitreq_next;
         irq_reg          <= irq_next;
      end
   end

   // Waitrequest is high unless an answer is ready; idle bus sees it high
   assign AVS_READDATA    = rdata_reg;
   assign AVS_WAITREQUEST = waitreq_reg;
   assign IRQ_PIN         = irq_reg;
endmodule

// ### rtl/link_status_summary_pkg.sv
package link_status_summary_pkg;
   // Register word offsets (index); byte address is four times the index
   localparam logic [7:0]  IDX_LINK_STATUS_SUMMARY    = 8'h11;
   localparam logic [7:0]  IDX_EVENT_INTERRUPT_ENABLE = 8'h12;
   localparam logic [7:0]  IDX_EVENT_STATUS           = 8'h13;
   localparam logic [7:0]  IDX_EVENT_IRQ_CONTROL      = 8'h14;
   localparam int          ADDR_W                     = 10;
   localparam int          REG_W                      = 16;
   localparam int          EVENT_N                    = 16;
   // Reset values
   localparam logic [15:0] RESET_STATUS_SUMMARY       = 16'h0000;
   localparam logic [15:0] RESET_IRQ_ENABLE           = 16'h0000;
   localparam logic [15:0] RESET_EVENT_STATUS         = 16'h0000;
   localparam logic        RESET_IRQ_POLARITY         = 1'b1;
   // Field positions in the link status summary
   localparam int          POS_SPEED                  = 14;
   localparam int          POS_FULL_DUPLEX            = 13;
   localparam int          POS_PAGE_RECEIVED          = 12;
   localparam int          POS_NEG_RESOLVED           = 11;
   localparam int          POS_LINK_UP                = 10;
   localparam int          POS_CD_CROSSED             = 9;
   localparam int          POS_AB_CROSSED             = 8;
   localparam int          POS_DOWNSHIFT              = 7;
   localparam int          POS_SLEEP                  = 6;
   localparam int          POS_CHAN_POLARITY          = 2;
   localparam int          POS_TEN_POLARITY           = 1;
   localparam int          POS_OVERLONG_TX            = 0;
   // Polarity bit inside the irq control register
   localparam int          POS_IRQ_POLARITY           = 13;
   // Speed codes
   localparam logic [1:0]  SPEED_10M                  = 2'h0;
   localparam logic [1:0]  SPEED_100M                 = 2'h1;
   localparam logic [1:0]  SPEED_1000M                = 2'h2;
   localparam logic [1:0]  SPEED_RESERVED             = 2'h3;
   // Read data returned one cycle after the request is seen
   localparam int          READ_LATENCY               = 1;
endpackage

// ### verification/link_status_summary_asserts.sv
`timescale 1ns/1ps
module link_status_summary_asserts
   import link_status_summary_pkg::*;
(
   input wire logic [link_status_summary_pkg::ADDR_W-1:0] AVS_ADDRESS,
   input wire logic                SYS_CLK,
   input wire logic                RST,
   input wire logic                AVS_READ,
   input wire logic                AVS_WRITE,
   input wire logic [31:0]         AVS_READDATA,
   input wire logic                AVS_WAITREQUEST,
   input wire logic [1:0]          LINK_SPEED,
   input wire logic                FULL_DUPLEX_FLAG,
   input wire logic                PAGE_RECEIVED_PULSE,
   input wire logic                NEGOTIATION_RESOLVED_FLAG,
   input wire logic                LINK_UP,
   input wire logic                PAIRS_CD_CROSSED,
   input wire logic                PAIRS_AB_CROSSED,
   input wire logic                DOWNSHIFT_MASKING_ACTIVE,
   input wire logic                SLEEPING,
   input wire logic [3:0]          CHANNEL_POLARITY_REVERSED,
   input wire logic                TEN_POLARITY_NORMAL,
   input wire logic                OVERLONG_TX_DETECTED,
   input wire logic                IRQ_PIN
);
   logic take;
   logic rd11;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // Request accepted on this edge; summary reads single out the status word
   assign take = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST;
   assign rd11 = AVS_READ & AVS_WAITREQUEST & (AVS_ADDRESS[9:2] == IDX_LINK_STATUS_SUMMARY);
   a_answer_next: assert property (take |=> !AVS_WAITREQUEST) else $error("no answer");
   a_answer_once: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("long");
   a_upper_zero: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:16] == 16'h0000)
      else $error("upper half");
   a_speed_field: assert property (rd11 |=> AVS_READDATA[15:14] == $past(LINK_SPEED))
      else $error("speed");
   a_duplex_bit: assert property (rd11 |=> AVS_READDATA[13] == $past(FULL_DUPLEX_FLAG))
      else $error("duplex");
   a_link_bits: assert property (
      rd11 |=> AVS_READDATA[11:8] == $past({NEGOTIATION_RESOLVED_FLAG,
      LINK_UP, PAIRS_CD_CROSSED, PAIRS_AB_CROSSED})) else $error("link bits");
   a_low_bits: assert property (
      rd11 |=> AVS_READDATA[7:0] == $past({DOWNSHIFT_MASKING_ACTIVE,
      SLEEPING, CHANNEL_POLARITY_REVERSED, TEN_POLARITY_NORMAL, OVERLONG_TX_DETECTED}))
      else $error("low bits");
   a_page_seen: assert property (PAGE_RECEIVED_PULSE ##1 rd11 |=> AVS_READDATA[12])
      else $error("page lost");
   a_irq_reset: assert property ($fell(RST) |-> IRQ_PIN) else $error("irq reset");
   c_summary: cover property (rd11);
   c_write: cover property (take && AVS_WRITE);
   c_irq: cover property ($fell(IRQ_PIN));
endmodule

bind link_status_summary_and_int_enable link_status_summary_asserts i_chk (
   .SYS_CLK(SYS_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .LINK_SPEED(LINK_SPEED), .FULL_DUPLEX_FLAG(FULL_DUPLEX_FLAG), .LINK_UP(LINK_UP),
   .PAGE_RECEIVED_PULSE(PAGE_RECEIVED_PULSE),
   .NEGOTIATION_RESOLVED_FLAG(NEGOTIATION_RESOLVED_FLAG),
   .PAIRS_CD_CROSSED(PAIRS_CD_CROSSED), .PAIRS_AB_CROSSED(PAIRS_AB_CROSSED), .SLEEPING(SLEEPING),
   .DOWNSHIFT_MASKING_ACTIVE(DOWNSHIFT_MASKING_ACTIVE), .IRQ_PIN(IRQ_PIN),
   .CHANNEL_POLARITY_REVERSED(CHANNEL_POLARITY_REVERSED),
   .TEN_POLARITY_NORMAL(TEN_POLARITY_NORMAL), .OVERLONG_TX_DETECTED(OVERLONG_TX_DETECTED));

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
   import link_status_summary_pkg::*;
   logic              SYS_CLK = 1'b0;
   logic              RST = 1'b1;
   logic [ADDR_W-1:0] AVS_ADDRESS = 10'h000;
   logic              AVS_READ = 1'b0;
   logic              AVS_WRITE = 1'b0;
   logic [31:0]       AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
   logic [3:0]        AVS_BYTEENABLE = 4'h3, CHANNEL_POLARITY_REVERSED;
   logic [1:0]        LINK_SPEED;
   logic              AVS_WAITREQUEST, IRQ_PIN, PAGE_RECEIVED_PULSE = 1'b0;
   logic              FULL_DUPLEX_FLAG, NEGOTIATION_RESOLVED_FLAG, LINK_UP, PAIRS_CD_CROSSED;
   logic              PAIRS_AB_CROSSED, DOWNSHIFT_MASKING_ACTIVE, SLEEPING;
   logic              TEN_POLARITY_NORMAL, OVERLONG_TX_DETECTED;
   logic [14:0]       st = 15'h0000;
   logic [12:0]       pats [4] = '{13'h1555, 13'h0aaa, 13'h1fff, 13'h0000};
   logic [EVENT_N-1:0] EVENT_PULSES = 16'h0000;
   int                n_mismatch = 0;
   int                checks_done = 0;

   always #12.5 SYS_CLK = ~SYS_CLK;
   // One vector feeds all live status levels in summary bit order
   assign {LINK_SPEED, FULL_DUPLEX_FLAG, NEGOTIATION_RESOLVED_FLAG, LINK_UP, PAIRS_CD_CROSSED,
           PAIRS_AB_CROSSED, DOWNSHIFT_MASKING_ACTIVE, SLEEPING, CHANNEL_POLARITY_REVERSED,
           TEN_POLARITY_NORMAL, OVERLONG_TX_DETECTED} = st;

   link_status_summary_and_int_enable i_dut (
      .SYS_CLK(SYS_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .LINK_SPEED(LINK_SPEED),
      .FULL_DUPLEX_FLAG(FULL_DUPLEX_FLAG), .PAGE_RECEIVED_PULSE(PAGE_RECEIVED_PULSE),
      .NEGOTIATION_RESOLVED_FLAG(NEGOTIATION_RESOLVED_FLAG), .LINK_UP(LINK_UP),
      .PAIRS_CD_CROSSED(PAIRS_CD_CROSSED), .PAIRS_AB_CROSSED(PAIRS_AB_CROSSED),
      .DOWNSHIFT_MASKING_ACTIVE(DOWNSHIFT_MASKING_ACTIVE), .SLEEPING(SLEEPING),
      .CHANNEL_POLARITY_REVERSED(CHANNEL_POLARITY_REVERSED), .IRQ_PIN(IRQ_PIN),
      .TEN_POLARITY_NORMAL(TEN_POLARITY_NORMAL), .OVERLONG_TX_DETECTED(OVERLONG_TX_DETECTED),
      .EVENT_PULSES(EVENT_PULSES));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic give_verdict;
      $display("Comparisons %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Bus cycle held until waitrequest is seen low; an edge passes before the next
   task automatic acc(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      input logic [3:0] be);
      int n;
      n = 0;
      AVS_ADDRESS <= {idx, 2'b00};
      AVS_WRITEDATA <= wd;
      AVS_BYTEENABLE <= be;
      AVS_READ <= !wr;
      AVS_WRITE <= wr;
      do begin
         @(posedge SYS_CLK);
         n++;
      end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
      rd = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
      if (AVS_WAITREQUEST !== 1'b0) begin
         n_mismatch++;
         give_verdict();
      end
      @(posedge SYS_CLK);
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] e);
      acc(1'b0, idx, 32'h0, 4'h3);
      chk(nm, e, rd);
   endtask

   // Single-cycle event, then time for latch and registered pin to settle
   task automatic pulse(input int i);
      EVENT_PULSES <= 16'h0001 << i;
      @(posedge SYS_CLK);
      EVENT_PULSES <= 16'h0000;
      repeat (2) @(posedge SYS_CLK);
   endtask

   initial begin
      repeat (4) @(posedge SYS_CLK);
      RST <= 1'b0;
      chk("irq_rst", 32'h1, IRQ_PIN);
      rd_chk("summary_rst", IDX_LINK_STATUS_SUMMARY, 32'h0);
      rd_chk("enable_rst", IDX_EVENT_INTERRUPT_ENABLE, 32'h0);
      rd_chk("irqctl_rst", IDX_EVENT_IRQ_CONTROL, 32'h2000);
      // Every speed code, with each flag both set and clear across the table
      for (int i = 0; i < 4; i++) begin
         st <= {2'(i), pats[i]};
         @(posedge SYS_CLK);
         rd_chk("summary", IDX_LINK_STATUS_SUMMARY,
                {16'h0, 2'(i), pats[i][12], 1'b0, pats[i][11:0]});
      end
      // Live levels back to zero so the page checks see only the latched bit
      st <= 15'h0000;
      PAGE_RECEIVED_PULSE <= 1'b1;
      @(posedge SYS_CLK);
      PAGE_RECEIVED_PULSE <= 1'b0;
      rd_chk("page_set", IDX_LINK_STATUS_SUMMARY, 32'h1000);
      rd_chk("page_clr", IDX_LINK_STATUS_SUMMARY, 32'h0);
      acc(1'b1, IDX_EVENT_INTERRUPT_ENABLE, 32'ha55a, 4'h3);
      rd_chk("enable", IDX_EVENT_INTERRUPT_ENABLE, 32'ha55a);
      acc(1'b1, IDX_EVENT_INTERRUPT_ENABLE, 32'hffff, 4'h1);
      rd_chk("enable_lane", IDX_EVENT_INTERRUPT_ENABLE, 32'ha5ff);
      acc(1'b1, IDX_LINK_STATUS_SUMMARY, 32'hffff, 4'h3);
      rd_chk("summary_ro", IDX_LINK_STATUS_SUMMARY, 32'h0);
      rd_chk("unmapped", 8'h20, 32'h0);
      acc(1'b1, IDX_EVENT_INTERRUPT_ENABLE, 32'h0, 4'h3);
      pulse(3);
      chk("irq_masked", 32'h1, IRQ_PIN);
      rd_chk("ev_latched", IDX_EVENT_STATUS, 32'h8);
      // Each enable gates its own source only; the neighbour stays silent
      for (int i = 0; i < 16; i++) begin
         acc(1'b1, IDX_EVENT_INTERRUPT_ENABLE, 32'h1 << i, 4'h3);
         pulse((i + 1) % 16);
         chk("irq_other", 32'h1, IRQ_PIN);
         pulse(i);
         chk("irq_on", 32'h0, IRQ_PIN);
         rd_chk("ev", IDX_EVENT_STATUS, (32'h1 << i) | (32'h1 << ((i + 1) % 16)));
         @(posedge SYS_CLK);
         chk("irq_off", 32'h1, IRQ_PIN);
      end
      acc(1'b1, IDX_EVENT_IRQ_CONTROL, 32'h0, 4'h3);
      repeat (2) @(posedge SYS_CLK);
      chk("irq_pol", 32'h0, IRQ_PIN);
      rd_chk("irqctl", IDX_EVENT_IRQ_CONTROL, 32'h0);
      // Enable 15 is still set from the sweep; an active-high pin must rise
      pulse(15);
      chk("irq_pol_on", 32'h1, IRQ_PIN);
      give_verdict();
   end
endmodule
